/* shared/vic_pkg.sv */
// Package for the vectored interrupt controller: offsets, fields, vectors.
// Assumes a 32-bit AXI4-Lite register bus and one 20 MHz clock.
`default_nettype none
package vic_pkg;
  // ***********************************
  // Register map
  // ***********************************
  localparam logic [3:0] VIC_OFS_CTRL0 = 4'h0;
  localparam logic [3:0] VIC_OFS_CTRL1 = 4'h4;
  localparam logic [3:0] VIC_OFS_CTRL2 = 4'h8;
  localparam logic [3:0] VIC_OFS_CTRL3 = 4'hC;
  localparam logic [7:0] VIC_RST_CTRL = 8'h00;
  localparam logic [3:0] VIC_RST_EDGE = 4'h0;
  // ***********************************
  // Field positions
  // ***********************************
  localparam int VIC_BIT_GIE = 0;
  localparam int VIC_FLAG_OFS = 4;
  localparam int VIC_NSRC = 13;
  localparam int VIC_EDGE_B_POS = 2;
  // Source index order is priority order, 0 highest
  localparam int VIC_SRC_PIN_A = 0;
  localparam int VIC_SRC_PIN_B = 1;
  // ***********************************
  // Edge select codes
  // ***********************************
  localparam logic [1:0] VIC_EDGE_OFF = 2'h0;
  localparam logic [1:0] VIC_EDGE_RISE = 2'h1;
  localparam logic [1:0] VIC_EDGE_FALL = 2'h2;
  localparam logic [1:0] VIC_EDGE_BOTH = 2'h3;
  // ***********************************
  // Vectors
  // ***********************************
  localparam logic [11:0] VIC_VEC_BASE = 12'h004;
  localparam logic [11:0] VIC_VEC_STEP = 12'h004;
  // AXI responses
  localparam logic [1:0] VIC_RESP_OKAY = 2'h0;
  localparam logic [1:0] VIC_RESP_SLVERR = 2'h2;
endpackage : vic_pkg
`default_nettype wire

/* logic/vic_edge_det.sv */
// External pin edge detector with selectable edge type.
// Assumes the pin is already synchronous to aclk.
`default_nettype none
module vic_edge_det
  import vic_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic pin,
  input wire logic [1:0] edge_sel,
  output logic hit
);
  logic pin_prev;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_prev <= 1'b0;
    end else begin
      pin_prev <= pin;
    end
  end

  always_comb begin
    unique case (edge_sel)
      VIC_EDGE_OFF: hit = 1'b0;
      VIC_EDGE_RISE: hit = pin & ~pin_prev;
      VIC_EDGE_FALL: hit = ~pin & pin_prev;
      VIC_EDGE_BOTH: hit = pin ^ pin_prev;
    endcase
  end
endmodule : vic_edge_det
`default_nettype wire

/* logic/vic_core.sv */
// Vectored interrupt controller: flags, enables, priority, vector, wake.
// Assumes a core that pulses take and return, and reports stack full.
// Notes on behaviour
// - Source event sets its flag regardless of enable.
// - Flag without enable stays latched and never branches.
// - Global enable low blocks every interrupt.
// - Taking pushes next address and loads the source vector.
// - Return instruction pops saved address and resumes.
// - Every source has its own vector address.
// - Taking an interrupt clears the global enable.
// - Requests during blocking still set and hold flags.
// - Stack full holds off acknowledge; flags remain.
// - Simultaneous requests resolved by fixed priority.
// - Any flag set by its source event or pin edge wakes the device from sleep or idle; a flag set by a register write does not.
// - Pin flag set on the selected edge type.
// - Servicing a pin interrupt clears its flag and global enable.
// - Pull-high selection stays in effect on interrupt pins.
// - Flags read 1 pending; enables 1 enable.
// - First register: global, pin A, pin B, serial enables, flags.
// - Second register: low volt, adc, eeprom, time base A.
// - Third register: periodic P, periodic A, standard P, standard A.
// - Fourth register: time base B and async serial, others zero.
// - Edge select 00 off, 01 rise, 10 fall, 11 both.
//
// The implementer's own choices: the register offsets and register access over AXI4-Lite.
`default_nettype none
module vic_core
  import vic_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic ext_irq_pin_a,
  input wire logic ext_irq_pin_b,
  input wire logic pull_high_sel_a,
  input wire logic pull_high_sel_b,
  output logic pull_high_en_a,
  output logic pull_high_en_b,
  input wire logic [VIC_NSRC-1:0] src_event,
  input wire logic [3:0] edge_sel_in,
  input wire logic edge_sel_we,
  output logic [3:0] ext_edge_select_reg,
  input wire logic stack_full,
  input wire logic [11:0] next_pc,
  input wire logic take_ack,
  input wire logic return_from_interrupt,
  output logic irq_req,
  output logic [11:0] irq_vector,
  output logic [11:0] push_pc,
  output logic push_strobe,
  output logic pop_strobe,
  output logic wake
);
  // ***********************************
  // Source layout: index = priority
  // 0 pin A,1 pin B,2 serial,3 low volt,4 adc,5 eeprom,6 tb A,
  // 7 per P,8 per A,9 std P,10 std A,11 tb B,12 async serial
  // ***********************************
  logic global_irq_enable;
  logic [VIC_NSRC-1:0] en;
  logic [VIC_NSRC-1:0] flag;
  logic [VIC_NSRC-1:0] hw_set;
  logic [VIC_NSRC-1:0] sw_clr;
  logic [VIC_NSRC-1:0] sw_set;
  logic [VIC_NSRC-1:0] svc_clr;
  logic [VIC_NSRC-1:0] active;
  logic [3:0] win;
  logic any_active;
  logic hit_a;
  logic hit_b;
  logic aw_held;
  logic w_held;
  logic [3:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic do_write;
  logic gie_sw_we;
  logic gie_sw_val;

  function automatic logic [7:0] pack_reg(input logic [3:0] a, input logic [VIC_NSRC-1:0] e,
                                          input logic [VIC_NSRC-1:0] f, input logic g);
    logic [7:0] r;
    r = 8'h00;
    unique case (a)
      VIC_OFS_CTRL0: r = {1'b0, f[2], f[1], f[0], e[2], e[1], e[0], g};
      VIC_OFS_CTRL1: r = {f[6], f[5], f[4], f[3], e[6], e[5], e[4], e[3]};
      VIC_OFS_CTRL2: r = {f[10], f[9], f[8], f[7], e[10], e[9], e[8], e[7]};
      VIC_OFS_CTRL3: r = {2'b00, f[12], f[11], 2'b00, e[12], e[11]};
      default: r = 8'h00;
    endcase
    return r;
  endfunction : pack_reg

  function automatic logic valid_addr(input logic [3:0] a);
    return (a == VIC_OFS_CTRL0) || (a == VIC_OFS_CTRL1) ||
           (a == VIC_OFS_CTRL2) || (a == VIC_OFS_CTRL3);
  endfunction : valid_addr

  // ***********************************
  // External pins
  // ***********************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ext_edge_select_reg <= VIC_RST_EDGE;
    end else if (edge_sel_we) begin
      ext_edge_select_reg <= edge_sel_in;
    end
  end

  vic_edge_det u_edge_a (
    .aclk(aclk),
    .aresetn(aresetn),
    .pin(ext_irq_pin_a),
    .edge_sel(ext_edge_select_reg[1:0]),
    .hit(hit_a)
  );

  vic_edge_det u_edge_b (
    .aclk(aclk),
    .aresetn(aresetn),
    .pin(ext_irq_pin_b),
    .edge_sel(ext_edge_select_reg[VIC_EDGE_B_POS+1:VIC_EDGE_B_POS]),
    .hit(hit_b)
  );

  // Pull-high stays as selected whatever the pin function
  assign pull_high_en_a = pull_high_sel_a;
  assign pull_high_en_b = pull_high_sel_b;

  // ***********************************
  // AXI4-Lite write
  // ***********************************
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready = !w_held && !s_axi_bvalid;
  assign do_write = aw_held && w_held && !s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 4'h0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= VIC_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= valid_addr(aw_addr) ? VIC_RESP_OKAY : VIC_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Decode written byte 0 into global enable write, flag set and flag clear
  always_comb begin
    sw_set = '0;
    sw_clr = '0;
    gie_sw_we = 1'b0;
    gie_sw_val = 1'b0;
    if (do_write && w_strb[0]) begin
      unique case (aw_addr)
        VIC_OFS_CTRL0: begin
          gie_sw_we = 1'b1;
          gie_sw_val = w_data[VIC_BIT_GIE];
          for (int i = 0; i < 3; i++) begin
            sw_set[i] = w_data[VIC_FLAG_OFS+i];
            sw_clr[i] = ~w_data[VIC_FLAG_OFS+i];
          end
        end
        VIC_OFS_CTRL1: begin
          for (int i = 0; i < 4; i++) begin
            sw_set[3+i] = w_data[VIC_FLAG_OFS+i];
            sw_clr[3+i] = ~w_data[VIC_FLAG_OFS+i];
          end
        end
        VIC_OFS_CTRL2: begin
          for (int i = 0; i < 4; i++) begin
            sw_set[7+i] = w_data[VIC_FLAG_OFS+i];
            sw_clr[7+i] = ~w_data[VIC_FLAG_OFS+i];
          end
        end
        VIC_OFS_CTRL3: begin
          for (int i = 0; i < 2; i++) begin
            sw_set[11+i] = w_data[VIC_FLAG_OFS+i];
            sw_clr[11+i] = ~w_data[VIC_FLAG_OFS+i];
          end
        end
        default: begin
          sw_set = '0;
        end
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      en <= '0;
    end else if (do_write && w_strb[0]) begin
      unique case (aw_addr)
        VIC_OFS_CTRL0: en[2:0] <= w_data[3:1];
        VIC_OFS_CTRL1: en[6:3] <= w_data[3:0];
        VIC_OFS_CTRL2: en[10:7] <= w_data[3:0];
        VIC_OFS_CTRL3: en[12:11] <= w_data[1:0];
        default: en <= en;
      endcase
    end
  end

  // ***********************************
  // Flags and priority
  // ***********************************
  assign hw_set = {src_event[VIC_NSRC-1:2], hit_b, hit_a};

  // Hardware set wins over any clear so no event is lost
  generate
    for (genvar g = 0; g < VIC_NSRC; g++) begin : g_flag
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          flag[g] <= 1'b0;
        end else if (hw_set[g] || sw_set[g]) begin
          flag[g] <= 1'b1;
        end else if (sw_clr[g] || svc_clr[g]) begin
          flag[g] <= 1'b0;
        end
      end
    end
  endgenerate

  assign active = flag & en;
  assign any_active = |active;

  always_comb begin
    win = 4'h0;
    for (int i = VIC_NSRC - 1; i >= 0; i--) begin
      if (active[i]) begin
        win = 4'(i);
      end
    end
  end

  // Held off on stack full; core decides the instruction boundary
  assign irq_req = global_irq_enable && any_active && !stack_full;
  assign svc_clr = (take_ack && irq_req) ? (VIC_NSRC'(1) << win) : '0;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      global_irq_enable <= 1'b0;
    end else if (take_ack && irq_req) begin
      global_irq_enable <= 1'b0;
    end else if (gie_sw_we) begin
      global_irq_enable <= gie_sw_val;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_vector <= 12'h000;
      push_pc <= 12'h000;
      push_strobe <= 1'b0;
      pop_strobe <= 1'b0;
      wake <= 1'b0;
    end else begin
      push_strobe <= take_ack && irq_req;
      pop_strobe <= return_from_interrupt;
      wake <= |(hw_set & ~flag);
      irq_vector <= VIC_VEC_BASE + VIC_VEC_STEP * 12'(win);
      if (take_ack && irq_req) begin
        push_pc <= next_pc;
      end
    end
  end

  // ***********************************
  // AXI4-Lite read
  // ***********************************
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= VIC_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= {24'h000000, pack_reg(s_axi_araddr, en, flag, global_irq_enable)};
      s_axi_rresp <= valid_addr(s_axi_araddr) ? VIC_RESP_OKAY : VIC_RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ***********************************
  // Checks
  // ***********************************
  a_gie_blocks: assert property (@(posedge aclk) disable iff (!aresetn)
    !global_irq_enable |=> !push_strobe) else $error("acknowledge with global enable low");
  a_take_clears_gie: assert property (@(posedge aclk) disable iff (!aresetn)
    take_ack && irq_req |=> !global_irq_enable) else $error("global enable not cleared");
  a_stack_holdoff: assert property (@(posedge aclk) disable iff (!aresetn)
    stack_full |=> !push_strobe) else $error("acknowledge while stack full");
  a_event_sets_flag: assert property (@(posedge aclk) disable iff (!aresetn)
    src_event[4] |=> flag[4]) else $error("adc flag not set");
  a_disabled_no_req: assert property (@(posedge aclk) disable iff (!aresetn)
    (en == '0) |-> !irq_req) else $error("request with no enables");
  a_push_addr: assert property (@(posedge aclk) disable iff (!aresetn)
    take_ack && irq_req |=> push_strobe && push_pc == $past(next_pc)) else $error("push wrong");
  a_vector_pin_a: assert property (@(posedge aclk) disable iff (!aresetn)
    active[0] |=> irq_vector == VIC_VEC_BASE) else $error("pin A vector wrong");
  a_pin_a_rise: assert property (@(posedge aclk) disable iff (!aresetn)
    ext_edge_select_reg[1:0] == VIC_EDGE_RISE && $rose(ext_irq_pin_a) |=> flag[0])
    else $error("rising edge missed");
  a_wake_pulse: assert property (@(posedge aclk) disable iff (!aresetn)
    hw_set[5] && !flag[5] |=> wake) else $error("no wake");
  a_svc_clears: assert property (@(posedge aclk) disable iff (!aresetn)
    take_ack && irq_req && win == 4'h0 && !hw_set[0] |=> !flag[0]) else $error("pin flag kept");
endmodule : vic_core
`default_nettype wire

/* verification/vic_cpu_model.sv */
// Core model: takes interrupts, keeps a small return stack.
// Assumes vic_core drives irq_req, vector and push/pop strobes.
`default_nettype none
module vic_cpu_model
  import vic_pkg::*;
#(
  parameter int DEPTH = 2
)
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic irq_req,
  input wire logic [11:0] irq_vector,
  input wire logic [11:0] push_pc,
  input wire logic push_strobe,
  input wire logic pop_strobe,
  input wire logic ret_req,
  output logic take_ack,
  output logic return_from_interrupt,
  output logic stack_full,
  output logic [11:0] next_pc,
  output logic [11:0] taken_vec,
  output logic [11:0] taken_pc,
  output logic [11:0] popped
);
  // *****
  // Stack
  // *****
  logic [11:0] stk [8];
  logic [2:0] sp;
  logic seen;
  assign return_from_interrupt = ret_req;
  assign stack_full = (sp == 3'(DEPTH));
  // Take only after two sightings, so the registered vector has settled
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      seen <= 1'b0;
      take_ack <= 1'b0;
      next_pc <= 12'h100;
      sp <= 3'h0;
    end else begin
      seen <= irq_req;
      take_ack <= seen & irq_req & !take_ack;
      next_pc <= next_pc + 12'h001;
      if (take_ack & irq_req) begin
        taken_vec <= irq_vector;
        taken_pc <= next_pc;
      end
      if (push_strobe) begin
        stk[sp] <= push_pc;
        sp <= sp + 3'h1;
      end else if (pop_strobe) begin
        popped <= stk[sp - 3'h1];
        sp <= sp - 3'h1;
      end
    end
  end
endmodule : vic_cpu_model
`default_nettype wire

/* verification/vic_core_tb.sv */
// Bench for vic_core: bus tasks and directed interrupt sequences.
// Assumes the package, vic_core and vic_cpu_model compiled first.
`default_nettype none
module vic_core_tb
  import vic_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic aclk, aresetn, awv, awr, wv, wr_r, bv, brd, arv, arr, rv, rrd;
  logic pa, pb, pha, phb, phea, pheb, esel_we, sfull, take, ret, rfi, irq, push, pop, wake;
  logic [3:0] awa, ara, esel, eselq;
  logic [31:0] wd, rd;
  logic [1:0] bresp, rresp;
  logic [12:0] ev;
  logic [11:0] npc, vec, ppc, tvec, tpc, popped;
  logic [11:0] pcs [$];
  int n_fail, compares;
  vic_core uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wr_r), .s_axi_bresp(bresp),
    .s_axi_bvalid(bv), .s_axi_bready(brd), .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_rdata(rd), .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rrd), .ext_irq_pin_a(pa),
    .ext_irq_pin_b(pb), .pull_high_sel_a(pha), .pull_high_sel_b(phb), .pull_high_en_a(phea),
    .pull_high_en_b(pheb), .src_event(ev), .edge_sel_in(esel), .edge_sel_we(esel_we),
    .ext_edge_select_reg(eselq), .stack_full(sfull), .next_pc(npc), .take_ack(take),
    .return_from_interrupt(rfi), .irq_req(irq), .irq_vector(vec), .push_pc(ppc), .push_strobe(push),
    .pop_strobe(pop), .wake(wake));
  vic_cpu_model #(.DEPTH(2)) cpu (.aclk(aclk), .aresetn(aresetn), .irq_req(irq), .irq_vector(vec),
    .push_pc(ppc), .push_strobe(push), .pop_strobe(pop), .ret_req(ret), .take_ack(take),
    .return_from_interrupt(rfi), .stack_full(sfull), .next_pc(npc), .taken_vec(tvec), .taken_pc(tpc),
    .popped(popped));
  // *****
  // Tasks
  // *****
  task automatic tally_and_finish;
    if (n_fail == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : tally_and_finish
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic tmo;
    n_fail++;
    tally_and_finish();
  endtask : tmo
  // Bus masters hold everything until the sampling edge; ready is read at negedge
  task automatic wr(input logic [3:0] a, input logic [7:0] d, input logic [1:0] er);
    int i;
    logic ta, tw, tb;
    logic [1:0] r;
    awa <= a;
    wd <= {24'h0, d};
    awv <= 1'b1;
    wv <= 1'b1;
    brd <= 1'b1;
    for (i = 0; i < 40; i++) begin
      @(negedge aclk);
      ta = awv & awr;
      tw = wv & wr_r;
      tb = bv;
      r = bresp;
      @(posedge aclk);
      if (ta) awv <= 1'b0;
      if (tw) wv <= 1'b0;
      if (tb) break;
    end
    brd <= 1'b0;
    if (i == 40) tmo();
    chk({30'h0, r}, {30'h0, er});
    @(posedge aclk);
  endtask : wr
  task automatic rdc(input logic [3:0] a, input logic [31:0] e, input logic [1:0] er);
    int i;
    logic ta, tr;
    logic [31:0] d;
    logic [1:0] r;
    ara <= a;
    arv <= 1'b1;
    rrd <= 1'b1;
    for (i = 0; i < 40; i++) begin
      @(negedge aclk);
      ta = arv & arr;
      tr = rv;
      d = rd;
      r = rresp;
      @(posedge aclk);
      if (ta) arv <= 1'b0;
      if (tr) break;
    end
    rrd <= 1'b0;
    if (i == 40) tmo();
    chk(d, e);
    chk({30'h0, r}, {30'h0, er});
    @(posedge aclk);
  endtask : rdc
  task automatic evt(input int k);
    int i;
    ev <= 13'h1 << k;
    @(posedge aclk);
    ev <= 13'h0;
    for (i = 0; i < 4 && wake !== 1'b1; i++) @(negedge aclk);
    chk({31'h0, wake}, 32'h1);
    @(posedge aclk);
  endtask : evt
  task automatic taken(input int k);
    int i;
    for (i = 0; i < 40 && push !== 1'b1; i++) @(negedge aclk);
    if (i == 40) tmo();
    chk({20'h0, tvec}, {20'h0, VIC_VEC_BASE + VIC_VEC_STEP * 12'(k)});
    chk({20'h0, ppc}, {20'h0, tpc});
    pcs.push_back(tpc);
    @(posedge aclk);
  endtask : taken
  task automatic rti;
    int i;
    ret <= 1'b1;
    @(posedge aclk);
    ret <= 1'b0;
    for (i = 0; i < 8 && pop !== 1'b1; i++) @(negedge aclk);
    if (i == 8) tmo();
    @(posedge aclk);
    @(negedge aclk);
    chk({20'h0, popped}, {20'h0, pcs.pop_back()});
    @(posedge aclk);
  endtask : rti
  // *****
  // Main sequence
  // *****
  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end
  initial begin
    int k;
    logic [7:0] wv8 [4];
    logic [7:0] exp8 [4];
    n_fail = 0;
    compares = 0;
    {aresetn, awv, wv, brd, arv, rrd, pa, pb, phb, esel_we, ret} <= '0;
    {awa, ara, esel, wd, ev} <= '0;
    pha <= 1'b1;
    wv8 = '{8'hFE, 8'hFF, 8'hFF, 8'hFF};
    exp8 = '{8'h7E, 8'hFF, 8'hFF, 8'h33};
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk({30'h0, phea, pheb}, 32'h2);
    for (k = 0; k < 4; k++) rdc(4'(4 * k), 32'h0, VIC_RESP_OKAY);
    rdc(4'h2, 32'h0, VIC_RESP_SLVERR);
    wr(4'h2, 8'hFF, VIC_RESP_SLVERR);
    for (k = 3; k >= 0; k--) wr(4'(4 * k), wv8[k], VIC_RESP_OKAY);
    for (k = 0; k < 4; k++) rdc(4'(4 * k), {24'h0, exp8[k]}, VIC_RESP_OKAY);
    for (k = 0; k < 4; k++) wr(4'(4 * k), 8'h00, VIC_RESP_OKAY);
    // Flags latch with enables off and never branch
    wr(4'h0, 8'h01, VIC_RESP_OKAY);
    for (k = 2; k < 13; k++) evt(k);
    chk({31'h0, irq}, 32'h0);
    exp8 = '{8'h41, 8'hF0, 8'hF0, 8'h30};
    for (k = 0; k < 4; k++) rdc(4'(4 * k), {24'h0, exp8[k]}, VIC_RESP_OKAY);
    // Sources 2 to 12 pending at once: serviced in vector order
    wr(4'h0, 8'h40, VIC_RESP_OKAY);
    for (k = 1; k < 4; k++) wr(4'(4 * k), wv8[k], VIC_RESP_OKAY);
    wr(4'h0, 8'h4F, VIC_RESP_OKAY);
    for (k = 2; k < 13; k++) begin
      taken(k);
      rdc(4'h0, 32'h0E, VIC_RESP_OKAY);
      rti();
      wr(4'h0, 8'h0F, VIC_RESP_OKAY);
    end
    rdc(4'hC, 32'h03, VIC_RESP_OKAY);
    // Pin edge codes, both pins at once
    wr(4'h0, 8'h00, VIC_RESP_OKAY);
    for (k = 0; k < 4; k++) begin
      esel <= {2'(k), 2'(k)};
      esel_we <= 1'b1;
      @(posedge aclk);
      esel_we <= 1'b0;
      @(posedge aclk);
      chk({28'h0, eselq}, {28'h0, 2'(k), 2'(k)});
      pa <= 1'b1;
      pb <= 1'b1;
      repeat (3) @(posedge aclk);
      rdc(4'h0, k[0] ? 32'h30 : 32'h0, VIC_RESP_OKAY);
      wr(4'h0, 8'h00, VIC_RESP_OKAY);
      pa <= 1'b0;
      pb <= 1'b0;
      repeat (3) @(posedge aclk);
      rdc(4'h0, k[1] ? 32'h30 : 32'h0, VIC_RESP_OKAY);
      if (k < 3) wr(4'h0, 8'h00, VIC_RESP_OKAY);
    end
    wr(4'h0, 8'h37, VIC_RESP_OKAY);
    taken(0);
    rdc(4'h0, 32'h26, VIC_RESP_OKAY);
    rti();
    wr(4'h0, 8'h27, VIC_RESP_OKAY);
    taken(1);
    rdc(4'h0, 32'h06, VIC_RESP_OKAY);
    rti();
    // Blocked and stack-full hold-off; two nested levels fill the stack
    wr(4'h0, 8'h00, VIC_RESP_OKAY);
    evt(6);
    chk({31'h0, irq}, 32'h0);
    rdc(4'h4, 32'h8F, VIC_RESP_OKAY);
    // A flag already set gives no new wake-up
    ev <= 13'h0040;
    @(posedge aclk);
    ev <= 13'h0000;
    @(negedge aclk);
    chk({31'h0, wake}, 32'h0);
    @(posedge aclk);
    wr(4'h0, 8'h01, VIC_RESP_OKAY);
    taken(6);
    wr(4'h0, 8'h01, VIC_RESP_OKAY);
    evt(11);
    taken(11);
    wr(4'h0, 8'h01, VIC_RESP_OKAY);
    evt(12);
    repeat (10) @(posedge aclk);
    chk({31'h0, irq}, 32'h0);
    rdc(4'hC, 32'h23, VIC_RESP_OKAY);
    rti();
    taken(12);
    rti();
    rti();
    tally_and_finish();
  end
endmodule : vic_core_tb
`default_nettype wire
